// ==== cal_sync_ctrl.sv ====
// conversion and calibration sequencer with hold-off and result scaling
`timescale 1ns/1ps
`default_nettype none
`include "cal_sync_defs.svh"
module cal_sync_ctrl
  import cal_sync_pkg::*;
#(
  parameter int NCH = 8,
  parameter int TW  = 16
) (
  input  wire logic            clk_sys_i,      // 125 MHz clock
  input  wire logic            reset_n_i,      // async reset, low
  input  wire logic [2:0]      mode_i,         // mode code
  input  wire logic            mode_wr_i,      // mode write strobe
  input  wire logic [2:0]      chan_i,         // selected channel
  input  wire logic [2:0]      range_i,        // channel range code
  input  wire logic [TW-1:0]   conv_time_i,    // channel conversion time
  input  wire logic            sync_en_i,      // hold-off enable
  input  wire logic            io_dir_i,       // shared pin out enable
  input  wire logic            io_out_i,       // shared pin out value
  input  wire logic            gp_analog_i,    // general pin as analog
  input  wire logic            gp_out_i,       // general pin value
  input  wire logic            shared_io_pin_i,// shared pin level
  input  wire logic [23:0]     raw_i,          // raw converter result
  input  wire logic            raw_valid_i,    // raw result pulse
  input  wire logic            cal_wr_i,       // channel cal write
  input  wire logic            cal_fs_sel_i,   // 1 selects full-scale
  input  wire logic [23:0]     cal_wdata_i,    // channel cal data
  output logic                 shared_io_pin_o,    // shared pin out
  output logic                 shared_io_pin_oe_o, // shared pin enable
  output logic                 general_output_pin_o,    // gp value
  output logic                 general_output_pin_oe_o, // gp enable
  output logic                 common_analog_input_o,   // analog mux sel
  output logic                 io_in_o,        // shared pin readback
  output logic                 short_inputs_o, // internal input short
  output logic                 force_b2p5_o,   // force 2.5 V bipolar
  output logic                 busy_o,         // sequencer active
  output logic                 waiting_o,      // held off by pin
  output logic [NCH-1:0]       rdy_o,          // ready flags
  output logic [23:0]          data_o,         // scaled channel data
  output logic                 data_wr_o,      // data update pulse
  output logic [23:0]          adc_zs_o,       // converter zero-scale
  output logic [23:0]          adc_fs_o        // converter full-scale
);
  // parameter limits; the channel select port is three bits wide
  if (NCH < 1 || NCH > 8)
  begin : g_bad_nch
    $error("NCH must be 1 to 8");
  end
  if (TW < 2)
  begin : g_bad_tw
    $error("TW too small");
  end

  state_t            state_q;
  mode_t             mode_q;
  logic [TW-1:0]     cnt_q;
  logic              pin_q;
  logic [23:0]       ch_zs_q [NCH];
  logic [23:0]       ch_fs_q [NCH];
  logic              sync_low;
  logic              rise;
  logic              is_cal;
  logic              done;

  // saturating scaling arithmetic; wide signed intermediates keep precision
  function automatic logic [23:0] scale(
    input logic [23:0] raw, input logic [2:0] rng,
    input logic [23:0] azs, input logic [23:0] afs,
    input logic [23:0] czs, input logic [23:0] cfs);
    logic signed [63:0] a;
    logic signed [63:0] r;
    logic signed [63:0] coff;
    logic               bip;
    begin
      // [RULE9] range factor
      r = (rng == RANGE_U0P625 || rng == RANGE_B0P625) ? 64'sd2 : 64'sd1;
      bip = rng[0];
      // [RULE6] unsigned raw input
      a = $signed({40'h0, raw}) - r * $signed({40'h0, azs});
      // [RULE7] [RULE8] converter stage
      if (bip)
        a = ((a * $signed({40'h0, afs})) >>> `CS_BIP_DIV_SHIFT)
            + $signed({39'h0, `CS_BIP_OFFSET});
      else
        a = (a * $signed({40'h0, afs})) >>> `CS_FS_DIV_SHIFT;
      // [RULE10] sign and 22-bit magnitude
      coff = $signed({42'h0, czs[21:0]});
      if (czs[`CS_ZS_SIGN_BIT]) coff = -coff;
      a = ((a - r * coff) * $signed({40'h0, cfs})) >>> `CS_FS_DIV_SHIFT;
      // [RULE23] saturate
      if (a < 0) scale = 24'h000000;
      else if (a > $signed({40'h0, `CS_RAW_MAX})) scale = `CS_RAW_MAX;
      else scale = a[23:0];
    end
  endfunction : scale

  // hold-off decode; pin only acts as sync while io_dir_i is low, even when the device drives it low after calibration
  // [RULE2] shared pin role
  assign sync_low = sync_en_i && !io_dir_i && !shared_io_pin_i;
  assign rise     = shared_io_pin_i && !pin_q;
  assign is_cal   = (mode_q >= MODE_ADC_ZS);
  assign done     = (state_q == ST_RUN) && is_cal && (cnt_q <= 1);

  // pin history for edge detection
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
    if (!reset_n_i) pin_q <= 1'b1;
    else            pin_q <= shared_io_pin_i;

  // sequencer; host starts all work by writing a mode
  // [RULE11] mode write starts
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= ST_IDLE;
      mode_q  <= MODE_IDLE;
      cnt_q   <= '0;
    end
    else if (mode_wr_i)
    begin
      mode_q <= mode_t'(mode_i);
      cnt_q  <= conv_time_i;
      // [RULE4] wait for rising edge
      // only a line held low parks the start; a high line starts at once
      if (mode_t'(mode_i) == MODE_IDLE) state_q <= ST_IDLE;
      else if (sync_low) state_q <= ST_WAIT;
      else state_q <= ST_RUN;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE: ;
        // [RULE3] no processing while held
        ST_WAIT: if (rise && !sync_low) state_q <= ST_RUN;
        ST_RUN:
        begin
          // [RULE13] calibration length
          if (is_cal)
          begin
            if (done)
            begin
              // [RULE12] back to idle
              state_q <= ST_IDLE;
              mode_q  <= MODE_IDLE;
            end
            else cnt_q <= cnt_q - 1'b1;
          end
          else if (sync_low) state_q <= ST_WAIT;
          else if (raw_valid_i && mode_q == MODE_SINGLE)
          begin
            state_q <= ST_IDLE;
            mode_q  <= MODE_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // converter calibration registers, updated on calibration end
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      adc_zs_o <= `CS_ADC_ZS_RESET;
      adc_fs_o <= `CS_ADC_FS_RESET;
    end
    else if (done && mode_q == MODE_ADC_ZS) adc_zs_o <= raw_i;
    else if (done && mode_q == MODE_ADC_FS) adc_fs_o <= raw_i;
  end

  // channel calibration registers; host writes taken only in idle
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ch_zs_q[i] <= `CS_CH_ZS_RESET;
        ch_fs_q[i] <= `CS_CH_FS_RESET;
      end
    end
    // [RULE22] idle-only writes
    else if (cal_wr_i && state_q == ST_IDLE)
    begin
      if (cal_fs_sel_i) ch_fs_q[chan_i] <= cal_wdata_i;
      else              ch_zs_q[chan_i] <= cal_wdata_i;
    end
    // [RULE12] update targeted registers
    else if (done && mode_q == MODE_CH_ZS) ch_zs_q[chan_i] <= raw_i;
    else if (done && mode_q == MODE_CH_FS) ch_fs_q[chan_i] <= raw_i;
  end

  // scaled result output; conversions only, never during calibration
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_o    <= '0;
      data_wr_o <= 1'b0;
    end
    else
    begin
      data_wr_o <= 1'b0;
      // [RULE5] two-stage scaling
      if (state_q == ST_RUN && !is_cal && raw_valid_i && !sync_low)
      begin
        data_o    <= scale(raw_i, range_i, adc_zs_o, adc_fs_o,
                           ch_zs_q[chan_i], ch_fs_q[chan_i]);
        data_wr_o <= 1'b1;
      end
    end
  end

  // ready flags; set on data or calibration end, cleared by a new mode
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i) rdy_o <= '0;
    // [RULE12] all ready set
    else if (done) rdy_o <= '1;
    else if (data_wr_o) rdy_o[chan_i] <= 1'b1;
    else if (mode_wr_i) rdy_o <= '0;
  end

  // shared pin drive; calibration end pulls the sync line low
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shared_io_pin_o    <= 1'b0;
      shared_io_pin_oe_o <= 1'b0;
    end
    // [RULE12] sync pin low
    else if (done && sync_en_i)
    begin
      shared_io_pin_o    <= 1'b0;
      shared_io_pin_oe_o <= 1'b1;
    end
    else if (mode_wr_i || !sync_en_i)
    begin
      shared_io_pin_o    <= io_out_i;
      shared_io_pin_oe_o <= io_dir_i;
    end
  end

  // [RULE1] general pin role
  assign general_output_pin_o    = gp_out_i;
  assign general_output_pin_oe_o = !gp_analog_i;
  assign common_analog_input_o   = gp_analog_i;
  assign io_in_o                 = shared_io_pin_i;
  // [RULE15] zero-scale shorting
  assign short_inputs_o = (state_q == ST_RUN) && (mode_q == MODE_ADC_ZS);
  // [RULE17] forced range
  assign force_b2p5_o   = (state_q == ST_RUN) && (mode_q == MODE_ADC_FS);
  assign busy_o         = (state_q != ST_IDLE);
  assign waiting_o      = (state_q == ST_WAIT);

  property p_hold;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      sync_low |=> !data_wr_o;
  endproperty
  a_hold: assert property (p_hold) else $error("data during hold-off"); // [RULE3]

  sequence s_wait_rise;
    waiting_o ##1 (rise && !sync_low && !mode_wr_i);
  endsequence
  property p_start;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      s_wait_rise |=> busy_o && !waiting_o;
  endproperty
  a_start: assert property (p_start) else $error("no start on edge"); // [RULE4]

  property p_done;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (done && !mode_wr_i) |=> (rdy_o == '1) && !busy_o;
  endproperty
  a_done: assert property (p_done) else $error("calibration end wrong"); // [RULE12]

  property p_len;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (mode_wr_i && mode_i == 3'h3 && !sync_en_i && conv_time_i == 4)
      |=> (busy_o && !mode_wr_i) [*4] ##1 !busy_o;
  endproperty
  a_len: assert property (p_len) else $error("calibration length"); // [RULE13]

  property p_idle_wr;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cal_wr_i && busy_o && !done)
      |=> $stable(ch_zs_q[chan_i]) && $stable(ch_fs_q[chan_i]);
  endproperty
  a_idle_wr: assert property (p_idle_wr) else $error("write outside idle"); // [RULE22]

  property p_short;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      short_inputs_o |-> busy_o && !force_b2p5_o;
  endproperty
  a_short: assert property (p_short) else $error("short wrong"); // [RULE15]

  property p_gp;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      gp_analog_i |-> !general_output_pin_oe_o && common_analog_input_o;
  endproperty
  a_gp: assert property (p_gp) else $error("general pin role"); // [RULE1]

  property p_force;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      force_b2p5_o |-> mode_q == MODE_ADC_FS;
  endproperty
  a_force: assert property (p_force) else $error("forced range"); // [RULE17]
endmodule : cal_sync_ctrl
`default_nettype wire

// ==== cal_sync_defs.svh ====
// constants and rule summary for the calibration and sync control block
// Behaviour
// [RULE1] general output pin: digital out or analog
// [RULE2] shared pin: digital io or sync input
// [RULE3] hold-off enabled and pin low: no conversion
// [RULE4] start waits for hold-off pin rising edge; the code starts at once if the line is already high at the mode write
// [RULE5] scale by converter then channel calibration
// [RULE6] raw result is unsigned 24-bit
// [RULE7] unipolar scaling formula with 0x200000 divisors
// [RULE8] bipolar scaling adds 0x800000, divides 0x400000
// [RULE9] range factor 2 for 0.625 V ranges
// [RULE10] channel zero-scale is sign plus 22 bits
// [RULE11] host starts calibration by writing mode
// [RULE12] calibration end: update, ready, pin low, idle
// [RULE13] calibration lasts the channel conversion time
// [RULE14] host programs at least default conversion time
// [RULE15] zero-scale self-calibration shorts inputs internally
// [RULE16] host changes converter zero-scale via calibration
// [RULE17] full-scale self-calibration forces 2.5 V bipolar
// [RULE18] host uses system calibration for low ranges
// [RULE19] host runs zero-scale before full-scale system
// [RULE20] host self-calibrates before system calibration
// [RULE21] host sets channel range before system calibration
// [RULE22] channel calibration writes only while idle
// [RULE23] scaling saturates to 24 bits
`ifndef CAL_SYNC_DEFS_SVH
`define CAL_SYNC_DEFS_SVH
`define CS_FS_DIV_SHIFT    21
`define CS_BIP_DIV_SHIFT   22
`define CS_BIP_OFFSET      25'h0800000
`define CS_ZS_SIGN_BIT     22
`define CS_ADC_ZS_RESET    24'h000000
`define CS_ADC_FS_RESET    24'h200000
`define CS_CH_ZS_RESET     24'h000000
`define CS_CH_FS_RESET     24'h200000
`define CS_RAW_MAX         24'hffffff
`endif

// ==== cal_sync_pkg.sv ====
// types for the calibration and sync control block
package cal_sync_pkg;
  typedef enum logic [2:0] {
    MODE_IDLE      = 3'h0,
    MODE_SINGLE    = 3'h1,
    MODE_CONT      = 3'h2,
    MODE_ADC_ZS    = 3'h3,
    MODE_ADC_FS    = 3'h4,
    MODE_CH_ZS     = 3'h5,
    MODE_CH_FS     = 3'h6
  } mode_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WAIT  = 2'h1,
    ST_RUN   = 2'h2
  } state_t;
  typedef enum logic [2:0] {
    RANGE_U2P5  = 3'h0,
    RANGE_B2P5  = 3'h1,
    RANGE_U1P25 = 3'h2,
    RANGE_B1P25 = 3'h3,
    RANGE_U0P625 = 3'h4,
    RANGE_B0P625 = 3'h5
  } range_t;
endpackage : cal_sync_pkg

// ==== sync_host_model.sv ====
// host side of the shared sync pin, resolving the wire level
`timescale 1ns/1ps
`default_nettype none
module sync_host_model (
  input  wire logic drive_i,  // host drives the pin
  input  wire logic level_i,  // host level while driving
  input  wire logic dut_oe_i, // device drives the pin
  input  wire logic dut_i,    // device pin value
  output logic      pin_o     // resolved pin level
);
  // sync level source
  // device wins; a released wire floats to its pull-up
  assign pin_o = dut_oe_i ? dut_i : (drive_i ? level_i : 1'b1);
endmodule : sync_host_model
`default_nettype wire

// ==== test_adc_calibration_sync_control.sv ====
// self-checking bench for the calibration and sync sequencer
`timescale 1ns/1ps
`default_nettype none
module test_adc_calibration_sync_control
  import cal_sync_pkg::*;
();
  localparam longint D1 = 64'sh200000, D2 = 64'sh400000;
  localparam longint BO = 64'sh800000, MX = 64'shffffff;
  localparam longint MG = 64'sh3fffff;
  logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, mode_wr_i = 1'b0;
  logic [2:0]  mode_i = 3'h0, chan_i = 3'h0, range_i = 3'h0;
  logic [15:0] conv_time_i = 16'h0004;
  logic        sync_en_i = 1'b0, io_dir_i = 1'b0, io_out_i = 1'b0;
  logic        gp_analog_i = 1'b0, gp_out_i = 1'b0, raw_valid_i = 1'b0;
  logic        cal_wr_i = 1'b0, cal_fs_sel_i = 1'b0;
  logic [23:0] raw_i = 24'h0, cal_wdata_i = 24'h0, data_o;
  logic        host_drv = 1'b1, host_lvl = 1'b1, pin;
  logic        shared_io_pin_o, shared_io_pin_oe_o, general_output_pin_o;
  logic        general_output_pin_oe_o, common_analog_input_o, io_in_o;
  logic        short_inputs_o, force_b2p5_o, busy_o, waiting_o, data_wr_o;
  logic [7:0]  rdy_o;
  logic [23:0] adc_zs_o, adc_fs_o;
  logic [31:0] rnd = 32'h0001602a;
  longint      azs = 0, afs = D1, czs [8], cfs [8];
  int          fails = 0, compares = 0;

  cal_sync_ctrl #(.NCH(8), .TW(16)) dut_u (
    .clk_sys_i, .reset_n_i, .mode_i, .mode_wr_i, .chan_i, .range_i,
    .conv_time_i, .sync_en_i, .io_dir_i, .io_out_i, .gp_analog_i,
    .gp_out_i, .shared_io_pin_i(pin), .raw_i, .raw_valid_i, .cal_wr_i,
    .cal_fs_sel_i, .cal_wdata_i, .shared_io_pin_o, .shared_io_pin_oe_o,
    .general_output_pin_o, .general_output_pin_oe_o,
    .common_analog_input_o, .io_in_o, .short_inputs_o, .force_b2p5_o,
    .busy_o, .waiting_o, .rdy_o, .data_o, .data_wr_o, .adc_zs_o,
    .adc_fs_o);
  sync_host_model host_u (.drive_i(host_drv), .level_i(host_lvl),
    .dut_oe_i(shared_io_pin_oe_o), .dut_i(shared_io_pin_o), .pin_o(pin));

  // 125 MHz clock
  always #4 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  // reference scaling; the offset sign sits above a 22-bit magnitude
  function automatic longint ref_scale(input longint w, g, a, f, z, s);
    longint r, x, o;
    r = (g >= 4) ? 2 : 1;
    o = z[22] ? -(z & MG) : (z & MG);
    x = (w - r * a) * f;
    x = g[0] ? x / D2 + BO : x / D1;
    x = (x - r * o) * s / D1;
    return (x < 0) ? 0 : ((x > MX) ? MX : x);
  endfunction : ref_scale

  task automatic chk24(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk24

  task automatic chk1(input logic g, input logic e);
    chk24({23'h0, g}, {23'h0, e});
  endtask : chk1

  task automatic wr_mode(input logic [2:0] m, input logic [15:0] t);
    mode_i      <= m;
    conv_time_i <= t;
    mode_wr_i   <= 1'b1;
    @(posedge clk_sys_i);
    mode_wr_i   <= 1'b0;
  endtask : wr_mode

  task automatic cal_wr(input logic [2:0] c, input logic s,
                        input logic [23:0] d);
    chan_i       <= c;
    cal_fs_sel_i <= s;
    cal_wdata_i  <= d;
    cal_wr_i     <= 1'b1;
    @(posedge clk_sys_i);
    cal_wr_i     <= 1'b0;
    @(posedge clk_sys_i);
  endtask : cal_wr

  // raw result is held steady through the whole calibration
  task automatic run_cal(input logic [2:0] m, input logic [15:0] t,
                         input logic [23:0] r);
    int n;
    n = 0;
    raw_i <= r;
    wr_mode(m, t);
    @(negedge clk_sys_i);
    chk1(short_inputs_o, m == MODE_ADC_ZS);
    chk1(force_b2p5_o, m == MODE_ADC_FS);
    while (busy_o === 1'b1 && n < 200)
    begin
      n++;
      @(negedge clk_sys_i);
    end
    chk24(24'(n), 24'(t));
    chk24({16'h0, rdy_o}, 24'h0000ff);
    @(posedge clk_sys_i);
  endtask : run_cal

  task automatic grab(input logic [2:0] c, input logic [2:0] g,
                      input logic [23:0] r);
    raw_i       <= r;
    raw_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    raw_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    chk1(data_wr_o, 1'b1);
    chk24(data_o, 24'(ref_scale(r, g, azs, afs, czs[c], cfs[c])));
    @(negedge clk_sys_i);
    chk1(rdy_o[c], 1'b1);
    @(posedge clk_sys_i);
  endtask : grab

  task automatic results;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // watchdog, far beyond the couple of hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    results();
  end

  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      czs[i] = 0;
      cfs[i] = D1;
    end
    repeat (16) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(negedge clk_sys_i);
    chk24(adc_zs_o, 24'h000000);
    chk24(adc_fs_o, 24'h200000);
    chk1(shared_io_pin_oe_o, 1'b0);
    @(posedge clk_sys_i);
    gp_analog_i <= 1'b1;
    io_dir_i    <= 1'b1;
    io_out_i    <= 1'b0;
    host_drv    <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk1(general_output_pin_oe_o, 1'b0);
    chk1(common_analog_input_o, 1'b1);
    chk1(shared_io_pin_oe_o, 1'b1);
    chk1(shared_io_pin_o, 1'b0);
    // a released wire reads high, so a low level proves the drive
    chk1(io_in_o, 1'b0);
    @(posedge clk_sys_i);
    gp_analog_i <= 1'b0;
    gp_out_i    <= 1'b1;
    io_dir_i    <= 1'b0;
    host_drv    <= 1'b1;
    @(negedge clk_sys_i);
    chk1(general_output_pin_o, 1'b1);
    chk1(general_output_pin_oe_o, 1'b1);
    $display("test pins done");
    @(posedge clk_sys_i);
    run_cal(MODE_ADC_ZS, 16'h0004, 24'h000010);
    azs = 64'sh10;
    chk24(adc_zs_o, 24'h000010);
    run_cal(MODE_ADC_FS, 16'h0006, 24'h180000);
    afs = 64'sh180000;
    chk24(adc_fs_o, 24'h180000);
    chan_i  <= 3'h2;
    range_i <= RANGE_B1P25;
    run_cal(MODE_CH_ZS, 16'h0005, 24'h000020);
    run_cal(MODE_CH_FS, 16'h0007, 24'h300000);
    czs[2] = 64'sh20;
    cfs[2] = 64'sh300000;
    cal_wr(3'h3, 1'b0, 24'h400100);
    cal_wr(3'h3, 1'b1, 24'h3fffff);
    czs[3] = 64'sh400100;
    cfs[3] = MG;
    $display("test calibration done");
    // every range code, each channel with three of them, random raw above the offset
    for (int k = 0; k < 24; k++)
    begin
      rnd = xs(rnd);
      chan_i  <= 3'(k % 8);
      range_i <= 3'(k % 6);
      wr_mode(MODE_SINGLE, 16'h0008);
      grab(3'(k % 8), 3'(k % 6), rnd[31:8] | 24'h000100);
    end
    $display("test scaling done");
    sync_en_i <= 1'b1;
    host_lvl  <= 1'b0;
    chan_i    <= 3'h0;
    range_i   <= RANGE_U2P5;
    wr_mode(MODE_CONT, 16'h0008);
    cal_wr(3'h0, 1'b1, 24'h123456);
    raw_i       <= 24'h654321;
    raw_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    raw_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    chk1(waiting_o, 1'b1);
    chk1(data_wr_o, 1'b0);
    @(posedge clk_sys_i);
    host_lvl <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk1(waiting_o, 1'b0);
    chk1(busy_o, 1'b1);
    @(posedge clk_sys_i);
    grab(3'h0, RANGE_U2P5, 24'h654321);
    host_lvl <= 1'b0;
    raw_i    <= 24'h000010;
    wr_mode(MODE_ADC_ZS, 16'h0004);
    host_lvl <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk1(shared_io_pin_oe_o, 1'b1);
    chk1(shared_io_pin_o, 1'b0);
    chk1(io_in_o, 1'b0);
    chk1(busy_o, 1'b0);
    // own low drive holds the next start until the line is let go
    @(posedge clk_sys_i);
    wr_mode(MODE_CONT, 16'h0008);
    @(negedge clk_sys_i);
    chk1(waiting_o, 1'b1);
    @(negedge clk_sys_i);
    chk1(waiting_o, 1'b0);
    chk1(busy_o, 1'b1);
    // a line already high is no hold-off: start without waiting
    @(posedge clk_sys_i);
    wr_mode(MODE_CONT, 16'h0008);
    @(negedge clk_sys_i);
    chk1(waiting_o, 1'b0);
    chk1(busy_o, 1'b1);
    $display("test sync done");
    results();
  end
endmodule : test_adc_calibration_sync_control
`default_nettype wire
